// *** mhf_regs.sv ***
// Behaviour
// R1 - six-bit index: top bit word, five bit position
// R2 - index zero is low bit 0
// R3 - selected hash bit one accepts frame
// R4 - pass all multicast accepts every group frame
// R5 - both hash words host readable and writable
// R6 - command bits 15:11 carry PHY address
// R7 - command bits 10:6 select PHY register
// R8 - write select chooses write or read access
// R9 - busy stays high until access completes
// R10 - host waits busy low before command writes
// R11 - host holds data during PHY write
// R12 - read data loaded before busy clears
// R13 - data register low 16 bits, rest reserved
// R14 - pause frame carries programmed pause time
// R15 - full duplex busy until pause frame sent
// R16 - half duplex busy while back pressure asserted
// R17 - host checks flow busy before flow writes
// R18 - all received frames forwarded regardless
// R19 - flow enable turns on pause reception; code also needs full duplex set
// R20 - transmitter off: no pause, no back pressure
// R21 - flow bits 31:16 hold pause time
// R22 - valid pause stalls transmitter pause times slot
// R23 - host writes zero into flow busy bit
// R24 - hash index from destination address CRC
//
// Added by the designer: strobed register access.
module mhf_regs (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [9:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic RX_MC_VALID,
    input wire logic [47:0] RX_DEST_ADDR,
    output logic RX_MC_ACCEPT,
    output logic RX_FORWARD,
    input wire logic RX_PAUSE_VALID,
    input wire logic [15:0] RX_PAUSE_QUANTA,
    output logic TX_STALL,
    output logic PAUSE_TX_REQ,
    output logic [15:0] PAUSE_TX_TIME,
    input wire logic PAUSE_TX_DONE,
    output logic BACK_PRESSURE,
    input wire logic BP_RELEASE,
    output logic MDC,
    output logic MDIO_O,
    output logic MDIO_OE_N,
    input wire logic MDIO_I
);
    logic [31:0] hash_hi_r, hash_hi_nxt, hash_lo_r, hash_lo_nxt;
    logic [4:0] phy_addr_r, phy_addr_nxt, reg_idx_r, reg_idx_nxt;
    logic wsel_r, wsel_nxt;
    logic [15:0] mdata_r, mdata_nxt;
    logic [15:0] pause_time_r, pause_time_nxt;
    logic pass_ctl_r, pass_ctl_nxt, fc_en_r, fc_en_nxt;
    logic tx_en_r, tx_en_nxt, fdx_r, fdx_nxt, pass_mc_r, pass_mc_nxt;
    logic pause_pend_r, pause_pend_nxt, bp_r, bp_nxt;
    logic [25:0] stall_r, stall_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [31:0] crc;
    logic [5:0] hidx;
    logic hbit, eng_busy, eng_done, eng_start;
    logic [15:0] eng_rdata;
    logic flow_busy;

    // crc32 over the destination address, lsb first
    always_comb
    begin
        crc = 32'hffffffff;
        for (int i = 0; i < 48; i++)
            crc = (crc[0] ^ RX_DEST_ADDR[i]) ? ((crc >> 1) ^ 32'hedb88320) : (crc >> 1);
    end
    assign hidx = crc[31:26]; // see R24

    // word select by top index bit, position by low five
    assign hbit = hidx[5] ? hash_hi_r[hidx[4:0]] : hash_lo_r[hidx[4:0]]; // see R1 see R2
    assign RX_MC_ACCEPT = RX_MC_VALID && (pass_mc_r || hbit); // see R3 see R4
    // forwarding never depends on the pass control bit
    assign RX_FORWARD = 1'b1; // see R18

    assign eng_start = WR && (ADDR == mhf_pkg::ADDR_MGMT_CMD)
        && WDATA[mhf_pkg::CMD_BUSY_BIT] && !eng_busy; // see R9

    mhf_mgmt_engine u_eng (
        .clk(CLK),
        .rst_n(RST_N),
        .start(eng_start),
        .write_sel(WDATA[mhf_pkg::CMD_WRITE_BIT]),
        .phy_addr(WDATA[mhf_pkg::CMD_PHY_ADDR_LSB +: 5]),
        .reg_idx(WDATA[mhf_pkg::CMD_REG_IDX_LSB +: 5]),
        .wdata(mdata_r),
        .busy(eng_busy),
        .done(eng_done),
        .rdata(eng_rdata),
        .mdc(MDC),
        .mdio_o(MDIO_O),
        .mdio_oe_n(MDIO_OE_N),
        .mdio_i(MDIO_I)
    );

    assign flow_busy = pause_pend_r || bp_r; // see R15 see R16

    // register writes and engine results
    always_comb
    begin
        hash_hi_nxt = hash_hi_r;
        hash_lo_nxt = hash_lo_r;
        phy_addr_nxt = phy_addr_r;
        reg_idx_nxt = reg_idx_r;
        wsel_nxt = wsel_r;
        mdata_nxt = mdata_r;
        pause_time_nxt = pause_time_r;
        pass_ctl_nxt = pass_ctl_r;
        fc_en_nxt = fc_en_r;
        tx_en_nxt = tx_en_r;
        fdx_nxt = fdx_r;
        pass_mc_nxt = pass_mc_r;
        pause_pend_nxt = pause_pend_r;
        bp_nxt = bp_r;
        // far-side clears first, so a request in the same cycle wins
        if (PAUSE_TX_DONE && pause_pend_r)
            pause_pend_nxt = 1'b0; // see R15
        if (BP_RELEASE)
            bp_nxt = 1'b0; // see R16
        if (WR)
        begin
            unique case (ADDR)
                mhf_pkg::ADDR_HASH_HIGH: hash_hi_nxt = WDATA; // see R5
                mhf_pkg::ADDR_HASH_LOW: hash_lo_nxt = WDATA; // see R5
                mhf_pkg::ADDR_MGMT_CMD:
                    if (!eng_busy)
                    begin
                        phy_addr_nxt = WDATA[mhf_pkg::CMD_PHY_ADDR_LSB +: 5]; // see R6
                        reg_idx_nxt = WDATA[mhf_pkg::CMD_REG_IDX_LSB +: 5]; // see R7
                        wsel_nxt = WDATA[mhf_pkg::CMD_WRITE_BIT]; // see R8
                    end
                // writes during an access are dropped, data stays frozen
                mhf_pkg::ADDR_MGMT_DATA:
                    if (!eng_busy)
                        mdata_nxt = WDATA[15:0]; // see R13
                mhf_pkg::ADDR_FLOW:
                begin
                    pause_time_nxt = WDATA[mhf_pkg::FLOW_PAUSE_LSB +: 16]; // see R21
                    pass_ctl_nxt = WDATA[mhf_pkg::FLOW_PASS_BIT];
                    fc_en_nxt = WDATA[mhf_pkg::FLOW_EN_BIT];
                end
                mhf_pkg::ADDR_FLOW_CTRL:
                begin
                    tx_en_nxt = WDATA[mhf_pkg::FC_TX_EN_BIT];
                    fdx_nxt = WDATA[mhf_pkg::FC_FULL_DUPLEX_BIT];
                    pass_mc_nxt = WDATA[mhf_pkg::FC_PASS_ALL_MC_BIT];
                    if (WDATA[mhf_pkg::FC_REQUEST_BIT] && WDATA[mhf_pkg::FC_TX_EN_BIT])
                    begin
                        if (WDATA[mhf_pkg::FC_FULL_DUPLEX_BIT])
                            pause_pend_nxt = 1'b1;
                        else
                            bp_nxt = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        // read result lands in the data register as busy drops
        if (eng_done && !wsel_r)
            mdata_nxt = eng_rdata; // see R12
        // disabling the transmitter cancels both mechanisms
        if (!tx_en_nxt)
        begin
            pause_pend_nxt = 1'b0; // see R20
            bp_nxt = 1'b0; // see R20
        end
    end

    // pause reception: quanta times 1024 clock cycles, counted down one per cycle
    always_comb
    begin
        stall_nxt = stall_r;
        if (fc_en_r && fdx_r && RX_PAUSE_VALID) // see R19
            stall_nxt = {RX_PAUSE_QUANTA, 10'h000}; // see R22
        else if (stall_r != 26'h0)
            stall_nxt = stall_r - 26'h1;
    end

    // read mux; reserved bits read zero
    always_comb
    begin
        rdata_nxt = mhf_pkg::RESET_ZERO;
        if (RD)
        begin
            unique case (ADDR)
                mhf_pkg::ADDR_HASH_HIGH: rdata_nxt = hash_hi_r;
                mhf_pkg::ADDR_HASH_LOW: rdata_nxt = hash_lo_r;
                mhf_pkg::ADDR_MGMT_CMD:
                    rdata_nxt = {16'h0000, phy_addr_r, reg_idx_r, 4'h0, wsel_r, eng_busy};
                mhf_pkg::ADDR_MGMT_DATA: rdata_nxt = {16'h0000, mdata_r};
                mhf_pkg::ADDR_FLOW:
                    rdata_nxt = {pause_time_r, 13'h0000, pass_ctl_r, fc_en_r, flow_busy};
                mhf_pkg::ADDR_FLOW_CTRL:
                    rdata_nxt = {28'h0000000, 1'b0, pass_mc_r, fdx_r, tx_en_r};
                default: rdata_nxt = mhf_pkg::RESET_ZERO;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            hash_hi_r <= mhf_pkg::RESET_ZERO;
            hash_lo_r <= mhf_pkg::RESET_ZERO;
            phy_addr_r <= 5'h00;
            reg_idx_r <= 5'h00;
            wsel_r <= 1'b0;
            mdata_r <= 16'h0000;
            pause_time_r <= 16'h0000;
            pass_ctl_r <= 1'b0;
            fc_en_r <= 1'b0;
            tx_en_r <= 1'b0;
            fdx_r <= 1'b0;
            pass_mc_r <= 1'b0;
            pause_pend_r <= 1'b0;
            bp_r <= 1'b0;
            stall_r <= 26'h0;
            rdata_r <= mhf_pkg::RESET_ZERO;
        end
        else
        begin
            hash_hi_r <= hash_hi_nxt;
            hash_lo_r <= hash_lo_nxt;
            phy_addr_r <= phy_addr_nxt;
            reg_idx_r <= reg_idx_nxt;
            wsel_r <= wsel_nxt;
            mdata_r <= mdata_nxt;
            pause_time_r <= pause_time_nxt;
            pass_ctl_r <= pass_ctl_nxt;
            fc_en_r <= fc_en_nxt;
            tx_en_r <= tx_en_nxt;
            fdx_r <= fdx_nxt;
            pass_mc_r <= pass_mc_nxt;
            pause_pend_r <= pause_pend_nxt;
            bp_r <= bp_nxt;
            stall_r <= stall_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign RDATA = rdata_r;
    assign TX_STALL = (stall_r != 26'h0); // see R22
    assign PAUSE_TX_REQ = pause_pend_r;
    assign PAUSE_TX_TIME = pause_time_r; // see R14
    assign BACK_PRESSURE = bp_r; // see R16
endmodule

// *** mhf_pkg.sv ***
package mhf_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_HASH_HIGH = 8'h04;
    localparam logic [7:0] IDX_HASH_LOW = 8'h05;
    localparam logic [7:0] IDX_MGMT_CMD = 8'h06;
    localparam logic [7:0] IDX_MGMT_DATA = 8'h07;
    localparam logic [7:0] IDX_FLOW = 8'h08;
    localparam logic [7:0] IDX_FLOW_CTRL = 8'h09;
    localparam int ADDR_W = 10;
    localparam logic [ADDR_W-1:0] ADDR_HASH_HIGH = {IDX_HASH_HIGH, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_HASH_LOW = {IDX_HASH_LOW, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_MGMT_CMD = {IDX_MGMT_CMD, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_MGMT_DATA = {IDX_MGMT_DATA, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_FLOW = {IDX_FLOW, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_FLOW_CTRL = {IDX_FLOW_CTRL, 2'b00};
    // command register fields
    localparam int CMD_PHY_ADDR_LSB = 11;
    localparam int CMD_REG_IDX_LSB = 6;
    localparam int CMD_WRITE_BIT = 1;
    localparam int CMD_BUSY_BIT = 0;
    localparam logic [4:0] INTERNAL_PHY_ADDR = 5'h01;
    // flow register fields
    localparam int FLOW_PAUSE_LSB = 16;
    localparam int FLOW_PASS_BIT = 2;
    localparam int FLOW_EN_BIT = 1;
    localparam int FLOW_BUSY_BIT = 0;
    // own control register fields
    localparam int FC_TX_EN_BIT = 0;
    localparam int FC_FULL_DUPLEX_BIT = 1;
    localparam int FC_PASS_ALL_MC_BIT = 2;
    localparam int FC_REQUEST_BIT = 3;
    localparam logic [31:0] RESET_ZERO = 32'h00000000;
    // management timing
    localparam int CLK_MHZ = 100;
    localparam int MDC_PERIOD_NS = 400;
    localparam int MDC_HALF_CYC = (MDC_PERIOD_NS * CLK_MHZ) / 2000;
    localparam int SLOT_BITS = 512;
    typedef enum logic [1:0] {MHF_M_IDLE, MHF_M_SHIFT, MHF_M_DONE} mhf_mstate_t;
endpackage

// *** mhf_mgmt_engine.sv ***
// serial management frame engine: 32 preamble ones, then 32 frame bits
module mhf_mgmt_engine (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic write_sel,
    input wire logic [4:0] phy_addr,
    input wire logic [4:0] reg_idx,
    input wire logic [15:0] wdata,
    output logic busy,
    output logic done,
    output logic [15:0] rdata,
    output logic mdc,
    output logic mdio_o,
    output logic mdio_oe_n,
    input wire logic mdio_i
);
    mhf_pkg::mhf_mstate_t st_r, st_nxt;
    logic [7:0] div_r, div_nxt;
    logic [6:0] bit_r, bit_nxt;
    logic [63:0] sh_r, sh_nxt;
    logic [15:0] rd_r, rd_nxt;
    logic mdc_r, mdc_nxt;
    logic wsel_r, wsel_nxt;
    logic rise;

    assign rise = (div_r == 8'(mhf_pkg::MDC_HALF_CYC - 1)) && !mdc_r;

    // next state; data changes on falling mdc, read samples on rising mdc
    always_comb
    begin
        st_nxt = st_r;
        div_nxt = div_r;
        bit_nxt = bit_r;
        sh_nxt = sh_r;
        rd_nxt = rd_r;
        mdc_nxt = mdc_r;
        wsel_nxt = wsel_r;
        unique case (st_r)
            mhf_pkg::MHF_M_IDLE:
            begin
                mdc_nxt = 1'b0;
                div_nxt = 8'h00;
                if (start)
                begin
                    st_nxt = mhf_pkg::MHF_M_SHIFT;
                    bit_nxt = 7'h00;
                    wsel_nxt = write_sel;
                    sh_nxt = {32'hffffffff, 2'b01, write_sel ? 2'b01 : 2'b10,
                              phy_addr, reg_idx, write_sel ? 2'b10 : 2'b11,
                              write_sel ? wdata : 16'hffff};
                end
            end
            mhf_pkg::MHF_M_SHIFT:
            begin
                if (div_r == 8'(mhf_pkg::MDC_HALF_CYC - 1))
                begin
                    div_nxt = 8'h00;
                    mdc_nxt = !mdc_r;
                    if (mdc_r)
                    begin
                        sh_nxt = {sh_r[62:0], 1'b1};
                        bit_nxt = bit_r + 7'h01;
                        if (bit_r == 7'd63)
                            st_nxt = mhf_pkg::MHF_M_DONE;
                    end
                end
                else
                    div_nxt = div_r + 8'h01;
                if (rise && bit_r >= 7'd48)
                    rd_nxt = {rd_r[14:0], mdio_i};
            end
            mhf_pkg::MHF_M_DONE:
                st_nxt = mhf_pkg::MHF_M_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= mhf_pkg::MHF_M_IDLE;
            div_r <= 8'h00;
            bit_r <= 7'h00;
            sh_r <= 64'h0;
            rd_r <= 16'h0000;
            mdc_r <= 1'b0;
            wsel_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            div_r <= div_nxt;
            bit_r <= bit_nxt;
            sh_r <= sh_nxt;
            rd_r <= rd_nxt;
            mdc_r <= mdc_nxt;
            wsel_r <= wsel_nxt;
        end
    end

    // turnaround and read data: release the line from bit 46 on reads
    assign mdio_oe_n = (st_r != mhf_pkg::MHF_M_SHIFT) || (!wsel_r && bit_r >= 7'd46);
    assign busy = (st_r != mhf_pkg::MHF_M_IDLE);
    assign done = (st_r == mhf_pkg::MHF_M_DONE);
    assign rdata = rd_r;
    assign mdc = mdc_r;
    assign mdio_o = sh_r[63];
endmodule

// *** mhf_phy_model.sv ***
module mhf_phy_model #(
    parameter logic [4:0] PHY_ADDR = 5'h01
) (
    input wire logic mdc,
    input wire logic mdio,
    output logic drv_oe,
    output logic drv_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [32];
    logic [15:0] sr;
    logic [15:0] q;
    logic [4:0] ra;
    logic rd;
    logic wr;
    int cnt;
    // distinct power-up contents so a read shows which register answered
    initial
    begin
        cnt = -1;
        sr = '1;
        drv_oe = 1'b0;
        drv_o = 1'b1;
        for (int i = 0; i < 32; i++)
            mem[i] = 16'h5a00 + 16'(i);
    end
    // sample on the rising edge; read bits launched just after it
    always @(posedge mdc)
    begin
        sr = {sr[14:0], mdio};
        if (cnt < 0 && sr[2:0] == 3'b101)
            cnt = 2;
        else if (cnt >= 0)
            cnt++;
        if (cnt == 14)
        begin
            rd = sr[11:10] == 2'b10 && sr[9:5] == PHY_ADDR;
            wr = sr[11:10] == 2'b01 && sr[9:5] == PHY_ADDR;
            ra = sr[4:0];
            q = mem[sr[4:0]];
        end
        if (rd && cnt == 15)
            drv_oe = 1'b1;
        if (rd && cnt >= 15 && cnt < 32)
            drv_o = (cnt == 15) ? 1'b0 : q[31 - cnt];
        // end of frame; old bits cleared so they cannot fake a start
        if (cnt == 32)
        begin
            if (wr)
                mem[ra] = sr;
            cnt = -1;
            rd = 1'b0;
            wr = 1'b0;
            sr = '1;
            drv_oe = 1'b0;
            drv_o = ~drv_o;
        end
    end
endmodule

// *** mhf_regs_assertions.sv ***
module mhf_regs_chk (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [9:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    input wire logic RX_MC_VALID,
    input wire logic RX_MC_ACCEPT,
    input wire logic RX_FORWARD,
    input wire logic RX_PAUSE_VALID,
    input wire logic TX_STALL,
    input wire logic PAUSE_TX_REQ,
    input wire logic PAUSE_TX_DONE,
    input wire logic BACK_PRESSURE,
    input wire logic BP_RELEASE,
    input wire logic MDIO_OE_N
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ctl_r;
    logic [1:0] ctl_nxt;
    wire logic ctl_wr = WR && ADDR == mhf_pkg::ADDR_FLOW_CTRL;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    // shadow of tx enable and duplex, since neither reaches a port
    always_comb
    begin
        ctl_nxt = ctl_r;
        if (ctl_wr)
            ctl_nxt = WDATA[1:0];
    end
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            ctl_r <= 2'b00;
        else
            ctl_r <= ctl_nxt;
    end
    // request with the transmitter already on and duplex unchanged
    sequence s_req(logic fd);
        ctl_wr && WDATA[mhf_pkg::FC_REQUEST_BIT] && WDATA[0] && ctl_r[0] && WDATA[1] == fd
            && ctl_r[1] == fd && !PAUSE_TX_DONE && !BP_RELEASE;
    endsequence
    a_frames_forwarded: assert property (RX_FORWARD)
        else $error("received frames not forwarded");
    a_accept_needs_frame: assert property (!RX_MC_VALID |-> !RX_MC_ACCEPT)
        else $error("accept without a frame");
    a_pause_on_request: assert property (s_req(1'b1) |=> PAUSE_TX_REQ)
        else $error("pause request not raised");
    a_bp_on_request: assert property (s_req(1'b0) |=> BACK_PRESSURE)
        else $error("back pressure not raised");
    a_pause_holds: assert property (PAUSE_TX_REQ && !PAUSE_TX_DONE && !WR |=> PAUSE_TX_REQ)
        else $error("pause request dropped early");
    a_pause_ends: assert property (PAUSE_TX_REQ && PAUSE_TX_DONE && !WR |=> !PAUSE_TX_REQ)
        else $error("pause request outlived its frame");
    a_bp_holds: assert property (BACK_PRESSURE && !BP_RELEASE && !WR |=> BACK_PRESSURE)
        else $error("back pressure dropped early");
    a_bp_ends: assert property (BACK_PRESSURE && BP_RELEASE && !WR |=> !BACK_PRESSURE)
        else $error("back pressure outlived release");
    a_tx_off_quiet: assert property (!ctl_r[0] |-> !PAUSE_TX_REQ && !BACK_PRESSURE)
        else $error("flow action with transmitter off");
    a_stall_has_cause: assert property ($rose(TX_STALL) |-> $past(RX_PAUSE_VALID))
        else $error("stall without pause frame");
    a_busy_in_frame: assert property (RD && ADDR == mhf_pkg::ADDR_MGMT_CMD && !MDIO_OE_N
        |=> RDATA[mhf_pkg::CMD_BUSY_BIT])
        else $error("mgmt busy low during frame");
endmodule
bind mhf_regs mhf_regs_chk u_chk (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .RX_MC_VALID(RX_MC_VALID), .RX_MC_ACCEPT(RX_MC_ACCEPT),
    .RX_FORWARD(RX_FORWARD), .RX_PAUSE_VALID(RX_PAUSE_VALID), .TX_STALL(TX_STALL),
    .PAUSE_TX_REQ(PAUSE_TX_REQ), .PAUSE_TX_DONE(PAUSE_TX_DONE), .BACK_PRESSURE(BACK_PRESSURE),
    .BP_RELEASE(BP_RELEASE), .MDIO_OE_N(MDIO_OE_N));

// *** mhf_regs_tb.sv ***
module mhf_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [9:0] addr = '0;
    logic [31:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic mc_valid = 1'b0;
    logic [47:0] dest = '0;
    logic pause_valid = 1'b0;
    logic [15:0] quanta = '0;
    logic tx_done = 1'b0;
    logic bp_rel = 1'b0;
    logic [31:0] rdata;
    logic [31:0] v;
    logic [15:0] p_time;
    logic mc_acc, fwd, stall, p_req, bp, mdc, mdio_o, mdio_oe_n, phy_oe, phy_o;
    // pull-up holds the released line high
    wire logic mdio = !mdio_oe_n ? mdio_o : (phy_oe ? phy_o : 1'b1);
    int n_fail = 0;
    int comparisons = 0;
    logic [9:0] regs [7] = '{mhf_pkg::ADDR_HASH_HIGH, mhf_pkg::ADDR_HASH_LOW,
        mhf_pkg::ADDR_MGMT_CMD, mhf_pkg::ADDR_MGMT_DATA, mhf_pkg::ADDR_FLOW,
        mhf_pkg::ADDR_FLOW_CTRL, 10'h3fc};
    always #5 clk = ~clk;
    mhf_regs dut (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .RX_MC_VALID(mc_valid), .RX_DEST_ADDR(dest), .RX_MC_ACCEPT(mc_acc),
        .RX_FORWARD(fwd), .RX_PAUSE_VALID(pause_valid), .RX_PAUSE_QUANTA(quanta),
        .TX_STALL(stall), .PAUSE_TX_REQ(p_req), .PAUSE_TX_TIME(p_time),
        .PAUSE_TX_DONE(tx_done), .BACK_PRESSURE(bp), .BP_RELEASE(bp_rel), .MDC(mdc),
        .MDIO_O(mdio_o), .MDIO_OE_N(mdio_oe_n), .MDIO_I(mdio));
    mhf_phy_model u_phy (.mdc(mdc), .mdio(mdio), .drv_oe(phy_oe), .drv_o(phy_o));
    task automatic complete_run();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [9:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [9:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic rc(input logic [9:0] a, input logic [31:0] exp);
        rd_reg(a);
        chk(v, exp);
    endtask
    // one management access; polls busy so the next write is legal
    task automatic mii(input logic [4:0] ra, input logic [4:0] pa, input logic w);
        int n;
        if (w)
            wr_reg(mhf_pkg::ADDR_MGMT_DATA, 32'h0000beef);
        wr_reg(mhf_pkg::ADDR_MGMT_CMD, {16'h0000, pa, ra, 4'h0, w, 1'b1});
        rc(mhf_pkg::ADDR_MGMT_CMD, {16'h0000, pa, ra, 4'h0, w, 1'b1});
        n = 0;
        // busy time is not fixed, so only the final read is compared
        while (v[0] && n < 4000)
        begin
            rd_reg(mhf_pkg::ADDR_MGMT_CMD);
            n++;
        end
        chk(v, {16'h0000, pa, ra, 4'h0, w, 1'b0});
    endtask
    function automatic logic [5:0] hidx(input logic [47:0] a);
        logic [31:0] c;
        c = 32'hffffffff;
        for (int i = 0; i < 48; i++)
            c = (c >> 1) ^ ((c[0] ^ a[i]) ? 32'hedb88320 : 32'h00000000);
        return c[31:26];
    endfunction
    // table holds only the selected bit, then every bit but it
    task automatic hash_case(input logic [47:0] a);
        logic [63:0] t;
        t = 64'h1 << hidx(a);
        @(posedge clk);
        dest <= a;
        mc_valid <= 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            wr_reg(mhf_pkg::ADDR_HASH_HIGH, t[63:32]);
            wr_reg(mhf_pkg::ADDR_HASH_LOW, t[31:0]);
            #1 chk(mc_acc, 32'(k == 0));
            t = ~t;
        end
    endtask
    initial
    begin
        #400000;
        $display("watchdog expired");
        n_fail++;
        complete_run();
    end
    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 7; i++)
            rc(regs[i], 32'h0);
        wr_reg(mhf_pkg::ADDR_HASH_HIGH, 32'hdeadbeef);
        wr_reg(mhf_pkg::ADDR_HASH_LOW, 32'h13579bdf);
        wr_reg(10'h3fc, 32'hffffffff);
        rc(mhf_pkg::ADDR_HASH_HIGH, 32'hdeadbeef);
        rc(mhf_pkg::ADDR_HASH_LOW, 32'h13579bdf);
        rc(10'h3fc, 32'h0);
        $display("test registers done");
        for (int k = 0; k < 1024; k++)
            if (k < 4 || hidx(48'(k) << 8 | 48'h1) inside {6'd0, 6'd63})
                hash_case(48'(k) << 8 | 48'h1);
        wr_reg(mhf_pkg::ADDR_FLOW_CTRL, 32'h4);
        #1 chk(mc_acc, 32'h1);
        chk(fwd, 32'h1);
        @(posedge clk);
        mc_valid <= 1'b0;
        #1 chk(mc_acc, 32'h0);
        $display("test hash filter done");
        mii(5'd5, mhf_pkg::INTERNAL_PHY_ADDR, 1'b1);
        chk(u_phy.mem[5], 32'hbeef);
        mii(5'd5, mhf_pkg::INTERNAL_PHY_ADDR, 1'b0);
        rc(mhf_pkg::ADDR_MGMT_DATA, 32'hbeef);
        mii(5'd9, mhf_pkg::INTERNAL_PHY_ADDR, 1'b0);
        rc(mhf_pkg::ADDR_MGMT_DATA, 32'h5a09);
        mii(5'd9, 5'h03, 1'b0);
        rc(mhf_pkg::ADDR_MGMT_DATA, 32'hffff);
        $display("test management done");
        rc(mhf_pkg::ADDR_FLOW, 32'h0);
        wr_reg(mhf_pkg::ADDR_FLOW, 32'h12340002);
        rc(mhf_pkg::ADDR_FLOW, 32'h12340002);
        chk(p_time, 32'h1234);
        // full duplex then half duplex, each ended by its far-side signal
        for (int m = 0; m < 2; m++)
        begin
            wr_reg(mhf_pkg::ADDR_FLOW_CTRL, m ? 32'h1 : 32'h3);
            wr_reg(mhf_pkg::ADDR_FLOW_CTRL, m ? 32'h9 : 32'hb);
            rc(mhf_pkg::ADDR_FLOW, 32'h12340003);
            chk({p_req, bp}, m ? 32'h1 : 32'h2);
            @(posedge clk);
            tx_done <= !m;
            bp_rel <= m;
            @(posedge clk);
            tx_done <= 1'b0;
            bp_rel <= 1'b0;
            rc(mhf_pkg::ADDR_FLOW, 32'h12340002);
        end
        wr_reg(mhf_pkg::ADDR_FLOW_CTRL, 32'h9);
        wr_reg(mhf_pkg::ADDR_FLOW_CTRL, 32'h0);
        wr_reg(mhf_pkg::ADDR_FLOW_CTRL, 32'h8);
        #1 chk({p_req, bp}, 32'h0);
        rc(mhf_pkg::ADDR_FLOW, 32'h12340002);
        $display("test flow request done");
        wr_reg(mhf_pkg::ADDR_FLOW_CTRL, 32'h3);
        for (int e = 0; e < 2; e++)
        begin
            wr_reg(mhf_pkg::ADDR_FLOW, 32'h12340000 | 32'(e * 6));
            chk(fwd, 32'h1);
            pause_valid <= 1'b1;
            quanta <= 16'h0001;
            @(posedge clk);
            pause_valid <= 1'b0;
            @(posedge clk);
            #1 chk(stall, 32'(e));
            repeat (1022) @(posedge clk);
            #1 chk(stall, 32'(e));
            @(posedge clk);
            #1 chk(stall, 32'h0);
        end
        $display("test pause receive done");
        complete_run();
    end
endmodule
